// file: include/port_cfg_defs.vh
// Register offsets, field positions and reset values of the port pin mode block
`ifndef PORT_CFG_DEFS_VH
`define PORT_CFG_DEFS_VH

// Register addresses
`define ADDR_PORT1_MODE_B       8'hB4
`define ADDR_PORT2_MODE_A_MISC  8'hB5
`define ADDR_PORT2_MODE_B       8'hB6

// Fields of the port 2 mode a and misc register
`define BIT_PORT2_SCHMITT_SEL   7
`define BIT_PORT1_SCHMITT_SEL   6
`define BIT_PORT0_SCHMITT_SEL   5
`define BIT_CLOCK_OUT_EN        4
`define BIT_TIMER1_TOGGLE_EN    3
`define BIT_TIMER0_TOGGLE_EN    2

// Shared pin positions
`define PIN_TIMER1_TOGGLE       3'h7
`define PIN_TIMER0_TOGGLE       3'h2

// Reset values and masks
`define RESET_PORT2_MODE_A_MISC 8'h00
`define RESET_PORT2_MODE_B      2'h0
`define RESET_PORT1_MODE_B      8'h00
`define MASK_PORT2_MODE_B       8'h03

`endif

// file: core/pin_driver.v
// One port pin output driver decoding the two mode bits
`timescale 1ns/1ps

module pin_driver (
   // Mode and data
   input  wire pin_mode_bit_a_in,
   input  wire pin_mode_bit_b_in,
   input  wire level_in,
   // Pad controls
   output wire pad_out,
   output wire pad_oe_out,
   output wire pullup_out
);

   // Push-pull drives both levels, open drain and quasi drive low only
   assign pad_out    = level_in;
   assign pad_oe_out = (~pin_mode_bit_a_in & pin_mode_bit_b_in) |
                       (~(pin_mode_bit_a_in ^ pin_mode_bit_b_in) & ~level_in);
   // Weak pull-up only for quasi-bidirectional
   assign pullup_out = ~pin_mode_bit_a_in & ~pin_mode_bit_b_in & level_in;

endmodule // pin_driver

// file: core/port_pin_mode_config.v
// Port pin mode configuration registers and pad control
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "port_cfg_defs.vh"

// Behaviour
// - Pin mode from bit a and bit b: 00 quasi, 01 push-pull, 11 open drain.
// - Pattern 10 makes the pin input only, buffer chosen by port Schmitt bit.
// - Mode a bits 7,6,5 pick Schmitt for ports 2,1,0; 0 means TTL.
// - Clock output enable makes port 2 pin 0, the crystal out pin, drive its latch level with pull-up off.
// - Timer 1 toggle enable inverts port 0 bit 7 on each timer 1 overflow.
// - Timer 0 toggle enable inverts port 1 bit 2 on each timer 0 overflow.
// - Port 2 has mode bits for pins 1 and 0 only; other bits reserved.
// - Port 1 mode b register holds bit b for each port 1 pin.
module port_pin_mode_config (
   // Clock and reset
   input  wire       core_clk_in,
   input  wire       reset_n_in,
   // Register port
   input  wire [7:0] addr_in,
   input  wire [7:0] wdata_in,
   input  wire       wr_in,
   input  wire       rd_in,
   output reg  [7:0] rdata_out,
   // Mode a bits of ports 0 and 1 and bit b of port 0, held elsewhere
   input  wire [7:0] port0_mode_a_in,
   input  wire [7:0] port0_mode_b_in,
   input  wire [7:0] port1_mode_a_in,
   // Port latches and timer events
   input  wire [7:0] port0_latch_in,
   input  wire [7:0] port1_latch_in,
   input  wire [1:0] port2_latch_in,
   input  wire       timer0_ovf_in,
   input  wire       timer1_ovf_in,
   // Pad controls
   output reg  [7:0] port0_pad_out,
   output reg  [7:0] port0_oe_out,
   output reg  [7:0] port0_pullup_out,
   output reg  [7:0] port1_pad_out,
   output reg  [7:0] port1_oe_out,
   output reg  [7:0] port1_pullup_out,
   output reg  [1:0] port2_pad_out,
   output reg  [1:0] port2_oe_out,
   output reg  [1:0] port2_pullup_out,
   output reg  [2:0] schmitt_sel_out,
   output reg        clock_out_en_out
);

   // Registers
   reg  [7:0]  port2_mode_a_and_misc_reg;
   reg  [1:0]  port2_mode_b_reg;
   reg  [7:0]  port1_mode_b_reg;
   reg         t1_toggle_reg;
   reg         t0_toggle_reg;
   reg  [7:0]  rdata_next;
   // Decoded strobes and enables
   wire        wr_port2_mode_a;
   wire        wr_port2_mode_b;
   wire        wr_port1_mode_b;
   wire        clock_out_en;
   wire        timer1_toggle_out_en;
   wire        timer0_toggle_out_en;
   // Per-pin vectors, port 0 in the low bits
   wire [7:0]  p0_level;
   wire [7:0]  p1_level;
   wire [1:0]  p2_level;
   wire [17:0] mode_a_all;
   wire [17:0] mode_b_all;
   wire [17:0] level_all;
   wire [17:0] pad_all;
   wire [17:0] oe_all;
   wire [17:0] pu_all;

   // Enable bits of the misc register
   assign clock_out_en         = port2_mode_a_and_misc_reg[`BIT_CLOCK_OUT_EN];
   assign timer1_toggle_out_en = port2_mode_a_and_misc_reg[`BIT_TIMER1_TOGGLE_EN];
   assign timer0_toggle_out_en = port2_mode_a_and_misc_reg[`BIT_TIMER0_TOGGLE_EN];

   // Write strobes per register; unmapped addresses hit nothing
   assign wr_port2_mode_a = wr_in & (addr_in == `ADDR_PORT2_MODE_A_MISC);
   assign wr_port2_mode_b = wr_in & (addr_in == `ADDR_PORT2_MODE_B);
   assign wr_port1_mode_b = wr_in & (addr_in == `ADDR_PORT1_MODE_B);

   // Port 2 mode a pair plus Schmitt, clock out and toggle enables
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         port2_mode_a_and_misc_reg <= `RESET_PORT2_MODE_A_MISC;
      else if (wr_port2_mode_a)
         port2_mode_a_and_misc_reg <= wdata_in;
   end

   // Port 2 mode b; reserved bits are dropped, so they can only read zero
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         port2_mode_b_reg <= `RESET_PORT2_MODE_B;
      else if (wr_port2_mode_b)
         port2_mode_b_reg <= wdata_in[1:0];
   end

   // Port 1 mode b, one bit per pin
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         port1_mode_b_reg <= `RESET_PORT1_MODE_B;
      else if (wr_port1_mode_b)
         port1_mode_b_reg <= wdata_in;
   end

   // Read mux; unmapped addresses read zero, reserved bits read zero
   always @* begin
      rdata_next = 8'h00;
      case (addr_in)
         `ADDR_PORT2_MODE_A_MISC: rdata_next = port2_mode_a_and_misc_reg;
         `ADDR_PORT2_MODE_B:      rdata_next = {6'h00, port2_mode_b_reg};
         `ADDR_PORT1_MODE_B:      rdata_next = port1_mode_b_reg;
         default:                 rdata_next = 8'h00;
      endcase
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         rdata_out <= 8'h00;
      else if (rd_in)
         rdata_out <= rdata_next;
      else
         rdata_out <= 8'h00;
   end

   // Timer 1 toggle latch; follows the pin latch while off, so enabling starts clean
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         t1_toggle_reg <= 1'b0;
      else if (!timer1_toggle_out_en)
         t1_toggle_reg <= port0_latch_in[`PIN_TIMER1_TOGGLE];
      else if (timer1_ovf_in)
         t1_toggle_reg <= ~t1_toggle_reg;
   end

   // Timer 0 toggle latch, same scheme on port 1 bit 2
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         t0_toggle_reg <= 1'b0;
      else if (!timer0_toggle_out_en)
         t0_toggle_reg <= port1_latch_in[`PIN_TIMER0_TOGGLE];
      else if (timer0_ovf_in)
         t0_toggle_reg <= ~t0_toggle_reg;
   end

   // Shared pin levels; with enables off pins follow the latch
   assign p0_level = {timer1_toggle_out_en ? t1_toggle_reg : port0_latch_in[7],
                      port0_latch_in[6:0]};
   assign p1_level = {port1_latch_in[7:3],
                      timer0_toggle_out_en ? t0_toggle_reg : port1_latch_in[2],
                      port1_latch_in[1:0]};
   assign p2_level = port2_latch_in;

   assign mode_a_all = {port2_mode_a_and_misc_reg[1:0], port1_mode_a_in, port0_mode_a_in};
   assign mode_b_all = {port2_mode_b_reg, port1_mode_b_reg, port0_mode_b_in};
   assign level_all  = {p2_level, p1_level, p0_level};

   // One driver per pin decoding its mode pair
   genvar gi;
   generate
      for (gi = 0; gi < 18; gi = gi + 1) begin : g_pin
         pin_driver u_drv (
            .pin_mode_bit_a_in (mode_a_all[gi]),
            .pin_mode_bit_b_in (mode_b_all[gi]),
            .level_in          (level_all[gi]),
            .pad_out           (pad_all[gi]),
            .pad_oe_out        (oe_all[gi]),
            .pullup_out        (pu_all[gi])
         );
      end
   endgenerate

   // Port 0 pad controls
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port0_pad_out    <= 8'h00;
         port0_oe_out     <= 8'h00;
         port0_pullup_out <= 8'h00;
      end else begin
         port0_pad_out    <= pad_all[7:0];
         port0_oe_out     <= oe_all[7:0];
         port0_pullup_out <= pu_all[7:0];
      end
   end

   // Port 1 pad controls
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port1_pad_out    <= 8'h00;
         port1_oe_out     <= 8'h00;
         port1_pullup_out <= 8'h00;
      end else begin
         port1_pad_out    <= pad_all[15:8];
         port1_oe_out     <= oe_all[15:8];
         port1_pullup_out <= pu_all[15:8];
      end
   end

   // Port 2 pad controls; crystal out pin drives, pull-up off, while clock out is on
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port2_pad_out    <= 2'h0;
         port2_oe_out     <= 2'h0;
         port2_pullup_out <= 2'h0;
      end else begin
         port2_pad_out    <= pad_all[17:16];
         port2_pullup_out <= {pu_all[17], pu_all[16] & ~clock_out_en};
         port2_oe_out     <= {oe_all[17], oe_all[16] | clock_out_en};
      end
   end

   // Input buffer selects and clock output enable
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         schmitt_sel_out  <= 3'h0;
         clock_out_en_out <= 1'b0;
      end else begin
         schmitt_sel_out  <= {port2_mode_a_and_misc_reg[`BIT_PORT2_SCHMITT_SEL],
                              port2_mode_a_and_misc_reg[`BIT_PORT1_SCHMITT_SEL],
                              port2_mode_a_and_misc_reg[`BIT_PORT0_SCHMITT_SEL]};
         clock_out_en_out <= clock_out_en;
      end
   end

endmodule // port_pin_mode_config

// file: testbench/port_pin_mode_config_sva.sv
// Assertions on the port pin mode configuration block
`timescale 1ns/1ps
`include "port_cfg_defs.vh"
module port_pin_mode_config_sva (
   // Watched ports
   input wire       core_clk_in, reset_n_in, wr_in, rd_in, timer1_ovf_in, clock_out_en_out,
   input wire [7:0] addr_in, wdata_in, rdata_out, port0_mode_a_in, port0_mode_b_in,
   input wire [7:0] port0_latch_in, port0_pad_out, port0_oe_out, port0_pullup_out,
   input wire [2:0] schmitt_sel_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // Pin 0 mode, its latch, and a shadow of the timer 1 toggle enable
   wire [1:0] md = {port0_mode_a_in[0], port0_mode_b_in[0]};
   wire       lt = port0_latch_in[0];
   wire       w5 = wr_in && addr_in == `ADDR_PORT2_MODE_A_MISC;
   reg        t1e_reg;
   always @(posedge core_clk_in or negedge reset_n_in)
      if (!reset_n_in) t1e_reg <= 1'b0;
      else if (w5) t1e_reg <= wdata_in[`BIT_TIMER1_TOGGLE_EN];
   sequence s_w5; w5 ##1 !w5; endsequence
   sequence s_pp; !port0_mode_a_in[7] && port0_mode_b_in[7]; endsequence
   property p_sch; s_w5 |=> schmitt_sel_out == $past(wdata_in[7:5], 2); endproperty
   a_sch: assert property (p_sch) else $error("schmitt select");
   property p_cko; s_w5 |=> clock_out_en_out == $past(wdata_in[4], 2); endproperty
   a_cko: assert property (p_cko) else $error("clock out enable");
   property p_rsv;
      rd_in && addr_in == `ADDR_PORT2_MODE_B |=> rdata_out[7:2] == 6'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_qb; md == 2'b00 |=> port0_pullup_out[0] == $past(lt); endproperty
   a_qb: assert property (p_qb) else $error("quasi pull-up");
   property p_od; md == 2'b11 |=> port0_oe_out[0] != $past(lt) && !port0_pullup_out[0]; endproperty
   a_od: assert property (p_od) else $error("open drain");
   property p_hz; md == 2'b10 |=> !port0_oe_out[0] && !port0_pullup_out[0]; endproperty
   a_hz: assert property (p_hz) else $error("input only");
   property p_tg; (t1e_reg && timer1_ovf_in) ##0 s_pp ##1 t1e_reg ##0 s_pp
      |=> port0_pad_out[7] != $past(port0_pad_out[7]); endproperty
   a_tg: assert property (p_tg) else $error("timer 1 toggle");
   property p_fl; !t1e_reg ##0 s_pp |=> port0_pad_out[7] == $past(port0_latch_in[7]); endproperty
   a_fl: assert property (p_fl) else $error("shared pin latch");
endmodule // port_pin_mode_config_sva
bind port_pin_mode_config port_pin_mode_config_sva u_sva (.*);

// file: testbench/pin_board_model.sv
// Board side of the port 0 pins
`timescale 1ns/1ps
module pin_board_model (
   // Clock, reset and pad controls
   input  wire       core_clk_in, reset_n_in,
   input  wire [7:0] pad_in, oe_in, pullup_in,
   // Resolved pin levels
   output wire [7:0] level_out
);
   reg [7:0] last_reg;
   // Floating pins flip every cycle so a stale level never passes
   assign level_out = (oe_in & pad_in) | (~oe_in & (pullup_in | ~last_reg));
   always @(posedge core_clk_in or negedge reset_n_in)
      if (!reset_n_in) last_reg <= 8'h00;
      else last_reg <= level_out;
endmodule // pin_board_model

// file: testbench/tb_port_pin_mode_config.sv
// Testbench of the port pin mode configuration block
`timescale 1ns/1ps
`include "port_cfg_defs.vh"
module tb_port_pin_mode_config;
   reg        core_clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0;
   reg        timer0_ovf_in = 0, timer1_ovf_in = 0;
   reg  [7:0] addr_in = 0, wdata_in = 0, port0_mode_a_in = 0, port0_mode_b_in = 0;
   reg  [7:0] port1_mode_a_in = 0, port0_latch_in = 0, port1_latch_in = 0, e, l;
   reg  [1:0] port2_latch_in = 0;
   wire [7:0] rdata_out, port0_pad_out, port0_oe_out, port0_pullup_out, lvl;
   wire [7:0] port1_pad_out, port1_oe_out, port1_pullup_out;
   wire [1:0] port2_pad_out, port2_oe_out, port2_pullup_out;
   wire [2:0] schmitt_sel_out;
   wire       clock_out_en_out;
   integer    fails = 0, samples_checked = 0, i;
   port_pin_mode_config u_port_pin_mode_config (.*);
   pin_board_model u_pin_board_model (.core_clk_in, .reset_n_in, .pad_in(port0_pad_out),
      .oe_in(port0_oe_out), .pullup_in(port0_pullup_out), .level_out(lvl));
   initial forever #20 core_clk_in = ~core_clk_in;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // One register cycle; ends where read data stand
   task bus(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge core_clk_in);
         {wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
         @(posedge core_clk_in);
         {wr_in, rd_in} <= 2'b00;
         @(negedge core_clk_in);
      end
   endtask
   // Outputs trail their causes by one flop
   task settle;
      begin
         @(posedge core_clk_in);
         @(negedge core_clk_in);
      end
   endtask
   task pulse(input [1:0] t);
      begin
         @(posedge core_clk_in);
         {timer1_ovf_in, timer0_ovf_in} <= t;
         @(posedge core_clk_in);
         {timer1_ovf_in, timer0_ovf_in} <= 2'b00;
         settle;
      end
   endtask
   // Reset values, read back, reserved and unmapped bits
   task t_regs;
      begin
         bus(0, `ADDR_PORT1_MODE_B, 8'h00);
         chk(rdata_out, `RESET_PORT1_MODE_B);
         bus(0, `ADDR_PORT2_MODE_A_MISC, 8'h00);
         chk(rdata_out, `RESET_PORT2_MODE_A_MISC);
         bus(1, `ADDR_PORT1_MODE_B, 8'h5A);
         bus(1, `ADDR_PORT2_MODE_A_MISC, 8'hA5);
         bus(0, `ADDR_PORT1_MODE_B, 8'h00);
         chk(rdata_out, 8'h5A);
         bus(0, `ADDR_PORT2_MODE_A_MISC, 8'h00);
         chk(rdata_out, 8'hA5);
         bus(1, `ADDR_PORT2_MODE_B, 8'hFF);
         chk(rdata_out, 8'h00);
         bus(0, `ADDR_PORT2_MODE_B, 8'h00);
         chk(rdata_out, 8'h03);
         bus(0, 8'h10, 8'h00);
         chk(rdata_out, 8'h00);
         $display("regs done");
      end
   endtask
   // Every mode pair on every pin at both latch levels
   task t_modes;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            l = {8{i[2]}};
            e = i[1] ? (i[0] ? ~l : 8'h00) : (i[0] ? 8'hFF : ~l);
            bus(1, `ADDR_PORT1_MODE_B, {8{i[0]}});
            bus(1, `ADDR_PORT2_MODE_A_MISC, {6'h00, i[1], i[1]});
            bus(1, `ADDR_PORT2_MODE_B, {8{i[0]}});
            @(posedge core_clk_in);
            {port1_mode_a_in, port0_mode_a_in, port0_mode_b_in} <= {{16{i[1]}}, {8{i[0]}}};
            {port0_latch_in, port1_latch_in, port2_latch_in} <= {l, l, l[1:0]};
            settle;
            chk(port1_oe_out, e);
            chk(port0_oe_out, e);
            chk({6'h00, port2_oe_out}, e & 8'h03);
            chk(port1_pullup_out, (i[1] | i[0]) ? 8'h00 : l);
            chk(port0_pullup_out, (i[1] | i[0]) ? 8'h00 : l);
            chk({6'h00, port2_pullup_out}, (i[1] | i[0]) ? 8'h00 : l & 8'h03);
            chk(port1_pad_out & e, l & e);
            chk(port0_pad_out, l);
            chk({6'h00, port2_pad_out}, l & 8'h03);
         end
         $display("modes done");
      end
   endtask
   // Schmitt selects and clock out on a quasi port 2 pin at level 1
   task t_misc;
      begin
         bus(1, `ADDR_PORT2_MODE_B, 8'h00);
         for (i = 0; i < 8; i = i + 1) begin
            bus(1, `ADDR_PORT2_MODE_A_MISC, {i[2:0], 5'h10});
            settle;
            chk(schmitt_sel_out, i[2:0]);
            chk({clock_out_en_out, port2_oe_out}, 8'h05);
            chk({6'h00, port2_pullup_out}, 8'h02);
         end
         $display("misc done");
      end
   endtask
   // Push-pull on ports 0 and 1, port 2 left quasi, then toggles on and off
   task t_tog;
      begin
         @(posedge core_clk_in);
         {port0_mode_a_in, port0_mode_b_in, port1_mode_a_in} <= 24'h00FF00;
         {port0_latch_in, port1_latch_in} <= 16'h0000;
         bus(1, `ADDR_PORT1_MODE_B, 8'hFF);
         bus(1, `ADDR_PORT2_MODE_A_MISC, 8'h0C);
         settle;
         pulse(2'b10);
         chk({port0_pad_out[7], port1_pad_out[2], lvl[7]}, 8'h05);
         pulse(2'b11);
         chk({port0_pad_out[7], port1_pad_out[2]}, 8'h01);
         bus(1, `ADDR_PORT2_MODE_A_MISC, 8'h00);
         @(posedge core_clk_in);
         port0_latch_in <= 8'h80;
         pulse(2'b11);
         chk({port0_pad_out[7], port1_pad_out[2], clock_out_en_out}, 8'h04);
         $display("toggle done");
      end
   endtask
   // Mid-run reset returns pads and registers to their reset values
   task t_reset;
      begin
         @(posedge core_clk_in);
         reset_n_in <= 1'b0;
         @(negedge core_clk_in);
         chk(port0_pad_out, 8'h00);
         chk({clock_out_en_out, port2_oe_out, schmitt_sel_out}, 8'h00);
         @(posedge core_clk_in);
         reset_n_in <= 1'b1;
         bus(0, `ADDR_PORT1_MODE_B, 8'h00);
         chk(rdata_out, `RESET_PORT1_MODE_B);
         $display("reset done");
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d fails %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge core_clk_in);
      reset_n_in <= 1;
      t_regs;
      t_modes;
      t_misc;
      t_tog;
      t_reset;
      finish_test;
   end
   // Watchdog far past the roughly 130 cycles needed
   initial begin
      #400000;
      fails = fails + 1;
      finish_test;
   end
endmodule // tb_port_pin_mode_config
